// File: flogd_regs.vh
// Constants for the floating-point logarithm decoder
`ifndef FLOGD_REGS_VH
`define FLOGD_REGS_VH

// Instruction encoding
`define FLOGD_LINE 4'hF
`define FLOGD_OP_LOG10 7'h15
`define FLOGD_OP_LOG2 7'h16
`define FLOGD_EA_DREG 3'h0
`define FLOGD_EA_AREG 3'h1
`define FLOGD_EA_EXT 3'h7
`define FLOGD_EXT_ABSW 3'h0
`define FLOGD_EXT_ABSL 3'h1
`define FLOGD_EXT_PCD 3'h2
`define FLOGD_EXT_PCX 3'h3
`define FLOGD_EXT_IMM 3'h4

// Source formats
`define FLOGD_FMT_L 3'h0
`define FLOGD_FMT_S 3'h1
`define FLOGD_FMT_X 3'h2
`define FLOGD_FMT_P 3'h3
`define FLOGD_FMT_W 3'h4
`define FLOGD_FMT_D 3'h5
`define FLOGD_FMT_B 3'h6

// Exception status byte bit positions
`define FLOGD_X_UNORDERED_BRANCH_FLAG 7
`define FLOGD_X_SNAN 6
`define FLOGD_X_OPERAND_ERROR_FLAG 5
`define FLOGD_X_OVERFLOW_FLAG 4
`define FLOGD_X_UNDERFLOW_FLAG 3
`define FLOGD_X_DZ 2
`define FLOGD_X_RESULT_INEXACT_FLAG 1
`define FLOGD_X_DECIMAL_INPUT_INEXACT_FLAG 0

// Number formats
`define FLOGD_XBIAS 17'h0_3FFF
`define FLOGD_XEXP_MAX 15'h7FFF
`define FLOGD_SEXP_MAX 8'hFF
`define FLOGD_DEXP_MAX 11'h7FF
`define FLOGD_SBIAS 17'h0_007F
`define FLOGD_DBIAS 17'h0_03FF
`define FLOGD_INT_TOP 17'h0_003F
`define FLOGD_QNAN 80'h7FFF_FFFF_FFFF_FFFF_FFFF
`define FLOGD_LOG10_2 32'h4D10_4D42
`define FLOGD_FRAC_BITS 7'h20
`define FLOGD_ITERS 6'h20
`define FLOGD_BYTE0 8'h00

`endif

// File: flogd_fpr.v
// Eight floating-point data registers with registered reads
`timescale 1ns/1ns
`default_nettype none
module flogd_fpr (
  // Clock and control
  input wire clock,
  input wire clk_en,
  // Write port
  input wire we,
  input wire [2:0] widx,
  input wire [79:0] wdata,
  // Engine read port
  input wire [2:0] ridx_a,
  output reg [79:0] rdata_a,
  // Host read port
  input wire [2:0] ridx_b,
  output reg [79:0] rdata_b
);
  reg [79:0] mem [0:7];

  always @(posedge clock) begin
    if (clk_en) begin
      if (we) begin
        mem[widx] <= wdata;
      end
      rdata_a <= mem[ridx_a];
      rdata_b <= mem[ridx_b];
    end
  end
endmodule
`default_nettype wire

// File: flogd_cvt.v
// Source operand conversion to normalised extended precision
`timescale 1ns/1ns
`default_nettype none
`include "flogd_regs.vh"
module flogd_cvt (
  // Clock and control
  input wire clock,
  input wire nrst,
  input wire clk_en,
  input wire go,
  // Raw operand
  input wire [2:0] fmt,
  input wire [95:0] data,
  // Converted operand
  output reg sign_q,
  output reg zero_q,
  output reg inf_q,
  output reg nan_q,
  output reg inex_q,
  output reg [16:0] e_q,
  output reg [63:0] mant_q
);
  function [6:0] lzc64;
    input [63:0] v;
    integer i;
    reg found;
    begin
      lzc64 = 7'h40;
      found = 1'b0;
      for (i = 63; i >= 0; i = i - 1) begin
        if (v[i] && !found) begin
          lzc64 = 7'd63 - i[6:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  reg s;
  reg inf;
  reg nan;
  reg inex;
  reg [63:0] raw;
  reg [16:0] re;
  reg [6:0] lz;

  always @* begin
    s = 1'b0;
    inf = 1'b0;
    nan = 1'b0;
    inex = 1'b0;
    raw = 64'h0;
    re = `FLOGD_INT_TOP;
    case (fmt)
      `FLOGD_FMT_B: begin
        s = data[7];
        raw = {56'h0, s ? 8'h00 - data[7:0] : data[7:0]};
      end
      `FLOGD_FMT_W: begin
        s = data[15];
        raw = {48'h0, s ? 16'h0000 - data[15:0] : data[15:0]};
      end
      `FLOGD_FMT_L: begin
        s = data[31];
        raw = {32'h0, s ? 32'h0 - data[31:0] : data[31:0]};
      end
      `FLOGD_FMT_S: begin
        s = data[31];
        inf = (data[30:23] == `FLOGD_SEXP_MAX);
        nan = inf && (data[22:0] != 23'h0);
        raw = {data[30:23] != 8'h00, data[22:0], 40'h0};
        re = (data[30:23] == 8'h00) ? 17'h1_FF82 : {9'h0, data[30:23]} - `FLOGD_SBIAS;
      end
      `FLOGD_FMT_D: begin
        s = data[63];
        inf = (data[62:52] == `FLOGD_DEXP_MAX);
        nan = inf && (data[51:0] != 52'h0);
        raw = {data[62:52] != 11'h000, data[51:0], 11'h0};
        re = (data[62:52] == 11'h000) ? 17'h1_FC02 : {6'h0, data[62:52]} - `FLOGD_DBIAS;
      end
      `FLOGD_FMT_P: begin
        // Integer digit only; other digits and exponent mark inexact
        s = data[95];
        raw = {60'h0, data[67:64]};
        inf = (data[94:80] == `FLOGD_XEXP_MAX);
        nan = inf && (data[63:0] != 64'h0);
        inex = !inf && ((data[63:0] != 64'h0) || (data[91:80] != 12'h0));
      end
      default: begin
        s = data[95];
        inf = (data[94:80] == `FLOGD_XEXP_MAX);
        nan = inf && (data[62:0] != 63'h0);
        raw = data[63:0];
        re = (data[94:80] == 15'h0) ? 17'h1_C002 : {2'h0, data[94:80]} - `FLOGD_XBIAS;
      end
    endcase
    lz = lzc64(raw);
  end

  always @(posedge clock) begin
    if (!nrst) begin
      sign_q <= 1'b0;
      zero_q <= 1'b0;
      inf_q <= 1'b0;
      nan_q <= 1'b0;
      inex_q <= 1'b0;
      e_q <= 17'h0;
      mant_q <= 64'h0;
    end else if (clk_en && go) begin
      sign_q <= s;
      zero_q <= !inf && (raw == 64'h0);
      inf_q <= inf && !nan;
      nan_q <= nan;
      inex_q <= inex;
      e_q <= re - {10'h0, lz};
      mant_q <= raw << lz;
    end
  end
endmodule
`default_nettype wire

// File: flogd_top.v
// Logarithm instruction decoder and execution engine
`timescale 1ns/1ns
`default_nettype none
`include "flogd_regs.vh"
module flogd_top (
  // Clock and reset
  input wire clock,
  input wire nrst,
  input wire clk_en,
  // Own coprocessor identifier
  input wire [2:0] cp_id,
  // Instruction issue
  input wire instr_valid,
  input wire [15:0] op_word,
  input wire [15:0] ext_word,
  output wire instr_ack,
  output reg instr_illegal,
  // Operand fetch through effective address
  output reg ea_req,
  output reg [2:0] ea_mode,
  output reg [2:0] ea_reg,
  output reg [2:0] src_fmt,
  input wire op_valid,
  input wire [95:0] op_data,
  // Completion and status
  output wire busy,
  output reg done,
  output reg [7:0] exc_status,
  output reg [7:0] quotient_byte,
  // Host access to fp data registers
  input wire host_we,
  input wire [2:0] host_widx,
  input wire [79:0] host_wdata,
  input wire [2:0] host_ridx,
  output wire [79:0] host_rdata
);
  localparam [6:0] S_IDLE = 7'b000_0001;
  localparam [6:0] S_RDREG = 7'b000_0010;
  localparam [6:0] S_FETCH = 7'b000_0100;
  localparam [6:0] S_CONV = 7'b000_1000;
  localparam [6:0] S_ITER = 7'b001_0000;
  localparam [6:0] S_SCALE = 7'b010_0000;
  localparam [6:0] S_WRITE = 7'b100_0000;

  function [6:0] lzc64;
    input [63:0] v;
    integer i;
    reg found;
    begin
      lzc64 = 7'h40;
      found = 1'b0;
      for (i = 63; i >= 0; i = i - 1) begin
        if (v[i] && !found) begin
          lzc64 = 7'd63 - i[6:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  reg [6:0] state_q;
  reg [6:0] state_d;
  reg is_ten_q;
  reg rm_q;
  reg [2:0] dst_q;
  reg [2:0] spec_q;
  reg [95:0] src_q;
  reg [32:0] y_q;
  reg [31:0] frac_q;
  reg [5:0] cnt_q;
  reg neg_q;
  reg [48:0] mag_q;
  reg cv_go;

  wire cv_sign;
  wire cv_zero;
  wire cv_inf;
  wire cv_nan;
  wire cv_inex;
  wire [16:0] cv_e;
  wire [63:0] cv_mant;
  wire [79:0] fpr_rdata;

  // Decode of the two opcode words
  wire [2:0] f_id = op_word[11:9];
  wire [2:0] f_mode = op_word[5:3];
  wire [2:0] f_reg = op_word[2:0];
  wire f_rm = ext_word[14];
  wire [2:0] f_spec = ext_word[12:10];
  wire [2:0] f_dst = ext_word[9:7];
  wire [6:0] f_op = ext_word[6:0];

  wire mine = (op_word[15:12] == `FLOGD_LINE) && (f_id == cp_id);
  wire fixed_ok = (op_word[8:6] == 3'h0) && !ext_word[15] && !ext_word[13];
  wire op_ok = (f_op == `FLOGD_OP_LOG10) || (f_op == `FLOGD_OP_LOG2);
  wire dreg_fmt_ok = (f_spec == `FLOGD_FMT_B) || (f_spec == `FLOGD_FMT_W) ||
                     (f_spec == `FLOGD_FMT_L) || (f_spec == `FLOGD_FMT_S);
  wire fmt_ok = (f_spec != 3'h7);
  reg ea_ok;

  always @* begin
    case (f_mode)
      `FLOGD_EA_DREG: ea_ok = dreg_fmt_ok;
      `FLOGD_EA_AREG: ea_ok = 1'b0;
      `FLOGD_EA_EXT: begin
        ea_ok = (f_reg == `FLOGD_EXT_ABSW) || (f_reg == `FLOGD_EXT_ABSL) ||
                (f_reg == `FLOGD_EXT_IMM) || (f_reg == `FLOGD_EXT_PCD) ||
                (f_reg == `FLOGD_EXT_PCX);
      end
      default: ea_ok = 1'b1;
    endcase
  end

  // addressing fields not looked at when selector is 0
  wire src_ok = f_rm ? (ea_ok && fmt_ok) : 1'b1;
  wire idle = (state_q == S_IDLE);
  wire take = idle && instr_valid && mine;
  wire legal = fixed_ok && op_ok && src_ok;
  assign instr_ack = take && legal;
  assign busy = !idle;

  // Iterative squaring step for the fraction bits
  wire [65:0] sq = y_q * y_q;
  wire sq_hi = sq[65];
  wire [32:0] y_next = sq_hi ? sq[65:33] : sq[64:32];

  // Signed fixed-point result before scaling
  wire [48:0] fix_val = {cv_e[16:0], frac_q};
  wire fix_neg = fix_val[48];
  wire [48:0] fix_abs = fix_neg ? 49'h0 - fix_val : fix_val;
  wire [80:0] ten_prod = fix_abs * `FLOGD_LOG10_2;

  // Result normalisation
  wire [6:0] res_lz = lzc64({15'h0, mag_q});
  wire [63:0] res_mant = {15'h0, mag_q} << res_lz;
  wire [16:0] res_exp = `FLOGD_XBIAS + {10'h0, `FLOGD_FRAC_BITS} - 17'h1 - {10'h0, res_lz};

  // Special-operand outcome
  wire sp_neg = cv_sign && !cv_zero && !cv_nan;
  wire sp_pinf = cv_inf && !cv_sign;
  wire exact_one = !cv_zero && !cv_inf && !cv_nan && (cv_mant[62:0] == 63'h0);
  reg [79:0] result;

  always @* begin
    if (cv_nan) begin
      result = `FLOGD_QNAN;
    end else if (sp_neg) begin
      result = `FLOGD_QNAN;
    end else if (cv_zero) begin
      result = {1'b1, `FLOGD_XEXP_MAX, 64'h8000_0000_0000_0000};
    end else if (sp_pinf) begin
      result = {1'b0, `FLOGD_XEXP_MAX, 64'h8000_0000_0000_0000};
    end else if (mag_q == 49'h0) begin
      result = 80'h0;
    end else begin
      result = {neg_q, res_exp[14:0], res_mant};
    end
  end

  always @* begin
    state_d = state_q;
    cv_go = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (instr_ack) begin
          state_d = f_rm ? S_FETCH : S_RDREG;
        end
      end
      S_RDREG: begin
        cv_go = 1'b1;
        state_d = S_CONV;
      end
      S_FETCH: begin
        if (op_valid) begin
          cv_go = 1'b1;
          state_d = S_CONV;
        end
      end
      S_CONV: begin
        state_d = (cv_zero || cv_inf || cv_nan || cv_sign) ? S_WRITE : S_ITER;
      end
      S_ITER: begin
        if (cnt_q == `FLOGD_ITERS - 6'h1) begin
          state_d = S_SCALE;
        end
      end
      S_SCALE: begin
        state_d = S_WRITE;
      end
      S_WRITE: begin
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // Raw operand presented to the converter
  wire [95:0] cv_data = rm_q ? op_data : {fpr_rdata[79:64], 16'h0, fpr_rdata[63:0]};
  wire [2:0] cv_fmt = rm_q ? spec_q : `FLOGD_FMT_X;

  always @(posedge clock) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      is_ten_q <= 1'b0;
      rm_q <= 1'b0;
      dst_q <= 3'h0;
      spec_q <= 3'h0;
      src_q <= 96'h0;
      y_q <= 33'h0;
      frac_q <= 32'h0;
      cnt_q <= 6'h0;
      neg_q <= 1'b0;
      mag_q <= 49'h0;
      instr_illegal <= 1'b0;
      ea_req <= 1'b0;
      ea_mode <= 3'h0;
      ea_reg <= 3'h0;
      src_fmt <= 3'h0;
      done <= 1'b0;
      exc_status <= `FLOGD_BYTE0;
      quotient_byte <= `FLOGD_BYTE0;
    end else if (clk_en) begin
      state_q <= state_d;
      instr_illegal <= take && !legal;
      done <= 1'b0;
      if (instr_ack) begin
        is_ten_q <= (f_op == `FLOGD_OP_LOG10);
        rm_q <= f_rm;
        spec_q <= f_spec;
        dst_q <= f_dst;
        ea_req <= f_rm;
        ea_mode <= f_rm ? f_mode : 3'h0;
        ea_reg <= f_rm ? f_reg : 3'h0;
        src_fmt <= f_rm ? f_spec : `FLOGD_FMT_X;
      end
      if (state_q == S_FETCH && op_valid) begin
        ea_req <= 1'b0;
        src_q <= op_data;
      end
      if (state_q == S_CONV) begin
        // Binary point below bit 32, as the squaring step expects
        y_q <= {cv_mant[63:32], 1'b0};
        frac_q <= 32'h0;
        cnt_q <= 6'h0;
      end
      if (state_q == S_ITER) begin
        y_q <= y_next;
        frac_q <= {frac_q[30:0], sq_hi};
        cnt_q <= cnt_q + 6'h1;
      end
      if (state_q == S_SCALE) begin
        neg_q <= fix_neg;
        // scale by log base ten of two for the base-ten operation only
        mag_q <= is_ten_q ? ten_prod[80:32] : fix_abs;
      end
      if (state_q == S_WRITE) begin
        done <= 1'b1;
        exc_status[`FLOGD_X_UNORDERED_BRANCH_FLAG] <= 1'b0;
        exc_status[`FLOGD_X_SNAN] <= 1'b0;
        exc_status[`FLOGD_X_OPERAND_ERROR_FLAG] <= sp_neg;
        exc_status[`FLOGD_X_OVERFLOW_FLAG] <= 1'b0;
        exc_status[`FLOGD_X_UNDERFLOW_FLAG] <= 1'b0;
        exc_status[`FLOGD_X_DZ] <= cv_zero;
        exc_status[`FLOGD_X_RESULT_INEXACT_FLAG] <= !sp_neg && !cv_zero && !cv_inf && !cv_nan &&
                                      !exact_one;
        exc_status[`FLOGD_X_DECIMAL_INPUT_INEXACT_FLAG] <= rm_q && (spec_q == `FLOGD_FMT_P) && cv_inex;
        quotient_byte <= quotient_byte;
      end
    end
  end

  // write to destination, engine before host
  wire fpr_we = (state_q == S_WRITE) || (idle && host_we);
  wire [2:0] fpr_widx = (state_q == S_WRITE) ? dst_q : host_widx;
  wire [79:0] fpr_wdata = (state_q == S_WRITE) ? result : host_wdata;
  wire [2:0] fpr_ridx = instr_ack ? f_spec : spec_q;

  flogd_fpr u_fpr (
    .clock(clock),
    .clk_en(clk_en),
    .we(fpr_we),
    .widx(fpr_widx),
    .wdata(fpr_wdata),
    .ridx_a(fpr_ridx),
    .rdata_a(fpr_rdata),
    .ridx_b(host_ridx),
    .rdata_b(host_rdata)
  );

  flogd_cvt u_cvt (
    .clock(clock),
    .nrst(nrst),
    .clk_en(clk_en),
    .go(cv_go),
    .fmt(cv_fmt),
    .data(cv_data),
    .sign_q(cv_sign),
    .zero_q(cv_zero),
    .inf_q(cv_inf),
    .nan_q(cv_nan),
    .inex_q(cv_inex),
    .e_q(cv_e),
    .mant_q(cv_mant)
  );
endmodule
`default_nettype wire

// File: flogd_props.sv
// Port checker for the logarithm decoder
`timescale 1ns/1ns
`default_nettype none
module flogd_props (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Issue
  input wire logic [2:0] cp_id,
  input wire logic instr_valid,
  input wire logic [15:0] op_word,
  input wire logic [15:0] ext_word,
  input wire logic instr_ack,
  input wire logic instr_illegal,
  // Fetch and status
  input wire logic ea_req,
  input wire logic [2:0] ea_mode,
  input wire logic [2:0] ea_reg,
  input wire logic [2:0] src_fmt,
  input wire logic done,
  input wire logic [7:0] exc_status,
  input wire logic [7:0] quotient_byte
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_take_mem;
    instr_ack && ext_word[14];
  endsequence
  sequence s_take_reg;
    instr_ack && !ext_word[14];
  endsequence
  sequence s_fetch_shown;
    ea_req && ea_mode == $past(op_word[5:3]) && ea_reg == $past(op_word[2:0])
      && src_fmt == $past(ext_word[12:10]);
  endsequence
  AST_ID_MATCH: assert property (instr_ack |-> op_word[11:9] == cp_id)
    else $error("instruction taken with a foreign identifier");
  AST_ID_QUIET: assert property (instr_valid && op_word[11:9] != cp_id |=> !instr_illegal)
    else $error("foreign identifier flagged as illegal");
  AST_ENCODING: assert property (instr_ack |-> op_word[15:12] == 4'hF && op_word[8:6] == 3'h0
    && !ext_word[15] && !ext_word[13])
    else $error("instruction taken with bad fixed bits");
  AST_OPCODE: assert property (instr_ack |-> ext_word[6:0] inside {7'h15, 7'h16})
    else $error("instruction taken with unknown operation");
  AST_NO_PTR_DIRECT: assert property (s_take_mem |-> op_word[5:3] != 3'h1)
    else $error("pointer register direct accepted");
  AST_DREG_FMT: assert property (instr_ack && ext_word[14] && op_word[5:3] == 3'h0 |->
    ext_word[12:10] inside {3'h0, 3'h1, 3'h4, 3'h6})
    else $error("data register source with wide format accepted");
  AST_MEM_FETCH: assert property (s_take_mem |=> s_fetch_shown)
    else $error("memory source not requested with its fields");
  AST_REG_NO_FETCH: assert property (s_take_reg |=> !ea_req && ea_mode == 3'h0
    && src_fmt == 3'h2)
    else $error("register source started a fetch");
  AST_REG_DONE: assert property (s_take_reg |-> ##[4:38] done)
    else $error("register operation did not complete in time");
  AST_CLEARED: assert property (done |-> exc_status[7] == 1'b0 && exc_status[4:3] == 2'h0)
    else $error("unordered, overflow or underflow flag set");
  AST_QUOTIENT: assert property (quotient_byte == 8'h00)
    else $error("quotient byte changed");
endmodule
bind flogd_top flogd_props flogd_props_i (
  .clock(clock), .nrst(nrst), .cp_id(cp_id), .instr_valid(instr_valid), .op_word(op_word),
  .ext_word(ext_word), .instr_ack(instr_ack), .instr_illegal(instr_illegal), .ea_req(ea_req),
  .ea_mode(ea_mode), .ea_reg(ea_reg), .src_fmt(src_fmt), .done(done),
  .exc_status(exc_status), .quotient_byte(quotient_byte)
);
`default_nettype wire

// File: flogd_host.sv
// Host-side operand supplier for the logarithm decoder
`timescale 1ns/1ns
`default_nettype none
module flogd_host (
  // Clock and fetch request
  input wire logic clock,
  input wire logic ea_req,
  // Reply shape
  input wire logic [3:0] lag,
  input wire logic [95:0] word,
  // Operand reply
  output logic op_valid,
  output logic [95:0] op_data
);
  logic sent_q;
  logic [3:0] cnt_q;
  initial begin
    op_valid = 1'b0;
    op_data = 96'h0;
    sent_q = 1'b0;
    cnt_q = 4'h0;
  end
  // one operand per request, bus churns between
  always @(posedge clock) begin
    op_valid <= 1'b0;
    op_data <= ~op_data;
    if (!ea_req) begin
      sent_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (!sent_q && cnt_q == lag) begin
      op_valid <= 1'b1;
      op_data <= word;
      sent_q <= 1'b1;
    end else if (!sent_q) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: fp_log_instruction_decode_test.sv
// Self-checking bench for the logarithm decoder
`timescale 1ns/1ns
`default_nettype none
module fp_log_instruction_decode_test;
  logic clock = 0, nrst = 0, instr_valid = 0, host_we = 0;
  logic [2:0] cp_id = 3'h5, host_widx = 3'h0, host_ridx = 3'h0;
  logic [15:0] op_word = 16'h0, ext_word = 16'h0;
  logic [79:0] host_wdata = 80'h0;
  logic [3:0] lag = 4'h0;
  logic [95:0] word = 96'h0;
  wire instr_ack, instr_illegal, ea_req, op_valid, busy, done;
  wire [2:0] ea_mode, ea_reg, src_fmt;
  wire [7:0] exc_status, quotient_byte;
  wire [95:0] op_data;
  wire [79:0] host_rdata;
  integer errors = 0, comparisons = 0, ticks = 0;
  flogd_top flogd_top_i (.clock(clock), .nrst(nrst), .clk_en(1'b1), .cp_id(cp_id),
    .instr_valid(instr_valid), .op_word(op_word), .ext_word(ext_word),
    .instr_ack(instr_ack), .instr_illegal(instr_illegal), .ea_req(ea_req),
    .ea_mode(ea_mode), .ea_reg(ea_reg), .src_fmt(src_fmt), .op_valid(op_valid),
    .op_data(op_data), .busy(busy), .done(done), .exc_status(exc_status),
    .quotient_byte(quotient_byte), .host_we(host_we), .host_widx(host_widx),
    .host_wdata(host_wdata), .host_ridx(host_ridx), .host_rdata(host_rdata));
  flogd_host flogd_host_i (.clock(clock), .ea_req(ea_req), .lag(lag), .word(word),
    .op_valid(op_valid), .op_data(op_data));
  initial begin
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    ticks = ticks + 1;
    if (ticks == 20000) begin
      errors = errors + 1;
      conclude;
    end
  end
  task conclude;
    begin
      if (errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task check(input string name, input logic [79:0] seen, input logic [79:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task step;
    begin
      @(posedge clock);
      #1;
    end
  endtask
  function [15:0] opw(input [2:0] m, input [2:0] r);
    opw = {4'hF, cp_id, 3'h0, m, r};
  endfunction
  function [15:0] exw(input rm, input [2:0] s, input [2:0] d, input [6:0] c);
    exw = {1'b0, rm, 1'b0, s, d, c};
  endfunction
  task wreg(input [2:0] i, input [79:0] v);
    begin
      host_we = 1;
      host_widx = i;
      host_wdata = v;
      step;
      host_we = 0;
    end
  endtask
  task offer(input [15:0] o, input [15:0] e);
    integer n;
    begin
      op_word = o;
      ext_word = e;
      instr_valid = 1;
      #1;
      n = 0;
      while (instr_ack !== 1'b1 && n < 20) begin
        step;
        n = n + 1;
      end
      check("ack", instr_ack, 1);
      step;
      instr_valid = 0;
    end
  endtask
  task finish_op(input [2:0] r, output [7:0] x, output [79:0] v);
    integer n;
    begin
      n = 0;
      while (done !== 1'b1 && n < 200) begin
        step;
        n = n + 1;
      end
      check("done", done, 1);
      x = exc_status;
      host_ridx = r;
      step;
      v = host_rdata;
    end
  endtask
  task t_reg;
    logic [7:0] x;
    logic [79:0] v;
    begin
      wreg(3'h1, 80'h4002_8000_0000_0000_0000);
      offer(opw(3'h0, 3'h0), exw(1'b0, 3'h1, 3'h1, 7'h16));
      finish_op(3'h1, x, v);
      check("status", x, 0);
      check("result", v, 80'h4000_C000_0000_0000_0000);
      check("quotient", quotient_byte, 0);
    end
  endtask
  task t_specials;
    logic [110:0] rw;
    logic [7:0] x;
    logic [79:0] v;
    integer k;
    begin
      for (k = 0; k < 10; k = k + 1) begin
        case (k)
          0: rw = {80'h0, 7'h16, 16'hFFFF, 8'h04};
          1: rw = {80'h8000_0000_0000_0000_0000, 7'h16, 16'hFFFF, 8'h04};
          2: rw = {80'hC000_8000_0000_0000_0000, 7'h16, 16'h7FFF, 8'h20};
          3: rw = {80'hFFFF_0000_0000_0000_0000, 7'h16, 16'h7FFF, 8'h20};
          4: rw = {80'h7FFF_0000_0000_0000_0000, 7'h16, 16'h7FFF, 8'h00};
          5: rw = {80'h3FFF_8000_0000_0000_0000, 7'h15, 16'h0000, 8'h00};
          6: rw = {80'h0, 7'h15, 16'hFFFF, 8'h04};
          7: rw = {80'h4000_C000_0000_0000_0000, 7'h16, 16'h3FFF, 8'h02};
          8: rw = {80'h3FFE_8000_0000_0000_0000, 7'h16, 16'hBFFF, 8'h00};
          default: rw = {80'h4002_8000_0000_0000_0000, 7'h15, 16'h3FFE, 8'h00};
        endcase
        wreg(3'h2, rw[110:31]);
        offer(opw(3'h0, 3'h0), exw(1'b0, 3'h2, 3'h3, rw[30:24]));
        finish_op(3'h3, x, v);
        check("special sign exp", v[79:64], rw[23:8]);
        check("special status", x, rw[7:0]);
      end
    end
  endtask
  task t_mem;
    logic [192:0] rw;
    logic [7:0] x;
    logic [79:0] v;
    integer k;
    begin
      for (k = 0; k < 11; k = k + 1) begin
        case (k)
          0: rw = {9'o002, 96'h10, 80'h4001_8000_0000_0000_0000, 8'h00};
          1: rw = {9'o174, 96'h4000_0000, 80'h3FFF_8000_0000_0000_0000, 8'h00};
          2: rw = {9'o223, 96'h4002_0000_8000_0000_0000_0000, 80'h4000_C000_0000_0000_0000, 8'h00};
          3: rw = {9'o370, 96'h0008_0000_0000_0000_0001, 80'h4000_C000_0000_0000_0000, 8'h01};
          4: rw = {9'o431, 96'h2, 80'h3FFF_8000_0000_0000_0000, 8'h00};
          5: rw = {9'o554, 96'h4010_0000_0000_0000, 80'h4000_8000_0000_0000_0000, 8'h00};
          6: rw = {9'o645, 96'h1, 80'h0, 8'h00};
          7: rw = {9'o066, 96'h4, 80'h4000_8000_0000_0000_0000, 8'h00};
          8: rw = {9'o472, 96'h8, 80'h4000_C000_0000_0000_0000, 8'h00};
          9: rw = {9'o473, 96'h2, 80'h3FFF_8000_0000_0000_0000, 8'h00};
          default: rw = {9'o471, 96'hFFFE, 80'h7FFF_FFFF_FFFF_FFFF_FFFF, 8'h20};
        endcase
        lag = k[3:0];
        word = rw[183:88];
        offer(opw(rw[189:187], rw[186:184]), exw(1'b1, rw[192:190], 3'h7, 7'h16));
        check("fetch req", ea_req, 1);
        check("busy", busy, 1);
        check("fetch mode", {ea_mode, ea_reg}, rw[189:184]);
        check("fetch format", src_fmt, rw[192:190]);
        finish_op(3'h7, x, v);
        check("mem result", v, rw[87:8]);
        check("mem status", x, rw[7:0]);
      end
    end
  endtask
  task t_refuse;
    logic [32:0] rw;
    integer k;
    begin
      for (k = 0; k < 7; k = k + 1) begin
        case (k)
          0: rw = {4'hF, cp_id ^ 3'h1, 9'h0, exw(1'b0, 3'h1, 3'h1, 7'h16), 1'b0};
          1: rw = {opw(3'h1, 3'h0), exw(1'b1, 3'h0, 3'h1, 7'h16), 1'b1};
          2: rw = {opw(3'h0, 3'h0), exw(1'b1, 3'h2, 3'h1, 7'h16), 1'b1};
          3: rw = {opw(3'h7, 3'h5), exw(1'b1, 3'h0, 3'h1, 7'h16), 1'b1};
          4: rw = {opw(3'h2, 3'h0), exw(1'b1, 3'h0, 3'h1, 7'h17), 1'b1};
          5: rw = {4'hF, cp_id, 9'h50, exw(1'b1, 3'h0, 3'h1, 7'h16), 1'b1};
          default: rw = {opw(3'h2, 3'h0), exw(1'b1, 3'h7, 3'h1, 7'h16), 1'b1};
        endcase
        op_word = rw[32:17];
        ext_word = rw[16:1];
        instr_valid = 1;
        step;
        check("refused ack", instr_ack, 0);
        check("illegal", instr_illegal, rw[0]);
        step;
        check("refused busy", busy, 0);
        instr_valid = 0;
        step;
        step;
      end
    end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1;
    nrst = 1;
    t_reg;
    t_specials;
    t_mem;
    t_refuse;
    conclude;
  end
endmodule
`default_nettype wire
